//--- dac_scaler_pkg.sv
// constants and types shared by the analog output scaler
package dac_scaler_pkg;

  // register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] CTRL_OFFSET     = 8'h00;
  localparam logic [7:0] ZERO_OFFSET     = 8'h04;
  localparam logic [7:0] SPAN_OFFSET     = 8'h08;
  localparam logic [7:0] CALVAL_OFFSET   = 8'h0c;
  localparam logic [7:0] RATEDCAP_OFFSET = 8'h10;
  localparam logic [7:0] CONFIRM_OFFSET  = 8'h14;
  localparam logic [7:0] STATUS_OFFSET   = 8'h18;

  // control register fields
  localparam int CTRL_MODE_BIT  = 0;
  localparam int CTRL_CAL_BIT   = 1;
  localparam int CTRL_MAXV_LSB  = 8;
  localparam int CTRL_MAXV_MSB  = 11;
  // status register fields
  localparam int STAT_REJ_BIT   = 0;
  localparam int STAT_BUSY_BIT  = 1;
  localparam int STAT_CODE_LSB  = 16;

  // reset values and the legal limit range
  localparam logic [3:0]  MAXV_RESET  = 4'ha;
  localparam logic [31:0] ZERO_RESET  = 32'h0000_0000;
  localparam logic [31:0] SPAN_RESET  = 32'h0000_2710;
  localparam logic [3:0]  MAXV_MIN    = 4'h1;
  localparam logic [3:0]  MAXV_MAX    = 4'ha;

  // output scaling, voltage in millivolts, current in microamps
  localparam logic [15:0] MV_PER_VOLT  = 16'h03e8;
  localparam logic [15:0] OVR_PER_VOLT = 16'h044c;
  localparam logic [15:0] CUR_ZERO_UA  = 16'h0fa0;
  localparam logic [15:0] CUR_SPAN_UA  = 16'h3e80;
  localparam logic [15:0] CUR_LO_UA    = 16'h0960;
  localparam logic [15:0] CUR_HI_UA    = 16'h5460;

  // conversion timing
  localparam longint CLK_HZ       = 125_000_000;
  localparam longint CONV_RATE_HZ = 4000;
  localparam int     CONV_CYCLES  = int'(CLK_HZ / CONV_RATE_HZ);

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {MODE_VOLT, MODE_CURR} out_mode_e;

endpackage

//--- div_if.sv
// handshake between the scaler and its signed divider
interface div_if;
  logic               start;
  logic signed [47:0] dividend;
  logic signed [31:0] divisor;
  logic               done;
  logic signed [47:0] quotient;

  modport master (output start, output dividend, output divisor,
                  input done, input quotient);
  modport slave  (input start, input dividend, input divisor,
                  output done, output quotient);
endinterface

//--- signed_divider.sv
// sequential signed divider, one quotient bit per clock
module signed_divider (
  input  wire logic ref_clk,
  input  wire logic reset,
  div_if.slave      div
);

  typedef struct packed {
    logic        busy;
    logic [5:0]  cnt;
    logic [32:0] rem;
    logic [47:0] quo;
    logic [31:0] den;
    logic        neg;
    logic        done;
    logic [47:0] result;
  } div_state_s;

  div_state_s s;
  div_state_s n;

  assign div.done     = s.done;
  assign div.quotient = $signed(s.result);

  // restoring division on magnitudes; sign fixed at the end
  always_comb begin
    logic [32:0] trial;
    trial = 33'h0;
    n = s;
    n.done = 1'b0;
    if (div.start && !s.busy) begin
      n.busy = 1'b1;
      n.cnt  = 6'h30;
      n.rem  = 33'h0;
      n.quo  = div.dividend[47] ? 48'(-div.dividend) : div.dividend;
      n.den  = div.divisor[31] ? 32'(-div.divisor) : div.divisor;
      n.neg  = div.dividend[47] ^ div.divisor[31];
    end else if (s.busy) begin
      trial = {s.rem[31:0], s.quo[47]};
      if (trial >= {1'b0, s.den}) begin
        n.rem = trial - {1'b0, s.den};
        n.quo = {s.quo[46:0], 1'b1};
      end else begin
        n.rem = trial;
        n.quo = {s.quo[46:0], 1'b0};
      end
      n.cnt = s.cnt - 6'h1;
      if (s.cnt == 6'h1) begin
        n.busy   = 1'b0;
        n.done   = 1'b1;
        n.result = s.neg ? 48'(-n.quo) : n.quo;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

endmodule // signed_divider

//--- dac_output_scaler.sv
// indicator to analog output code scaler with AXI4-Lite registers
//
// The register addresses and the AXI4-Lite register port were decided locally.
module dac_output_scaler #(
  parameter int unsigned CONV_CYCLES = dac_scaler_pkg::CONV_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // measurement datapath
  input  wire logic        indValid,
  input  wire logic [31:0] indValue,
  // analog converter side
  output logic [15:0]      voltCode,
  output logic             voltEn,
  output logic [15:0]      currCode,
  output logic             currEn,
  output logic             dacStrobe
);

  typedef struct packed {
    logic                      awRdy;
    logic                      wRdy;
    logic                      bValid;
    logic [1:0]                bResp;
    logic                      arRdy;
    logic                      rValid;
    logic [31:0]               rData;
    logic [1:0]                rResp;
    logic [7:0]                awAddr;
    logic [31:0]               wData;
    logic [3:0]                wStrb;
    dac_scaler_pkg::out_mode_e mode;
    logic                      calTest;
    logic [3:0]                maxV;
    logic [31:0]               zero;
    logic [31:0]               span;
    logic [31:0]               calVal;
    logic [31:0]               ratedCap;
    logic                      rejected;
    logic [31:0]               tickCnt;
    logic [31:0]               sample;
    logic                      haveSample;
    logic                      busy;
    logic                      divStart;
    logic [47:0]               divNum;
    logic [31:0]               divDen;
    logic [15:0]               voltCode;
    logic [15:0]               currCode;
    logic                      voltEn;
    logic                      currEn;
    logic                      dacStrobe;
  } scaler_state_s;

  scaler_state_s s;
  scaler_state_s n;

  div_if div ();

  signed_divider u_div (
    .ref_clk (ref_clk),
    .reset   (reset),
    .div     (div.slave)
  );

  assign div.start    = s.divStart;
  assign div.dividend = $signed(s.divNum);
  assign div.divisor  = $signed(s.divDen);

  // every port below comes straight from the state register
  assign s_axi_awready = s.awRdy;
  assign s_axi_wready  = s.wRdy;
  assign s_axi_bvalid  = s.bValid;
  assign s_axi_bresp   = s.bResp;
  assign s_axi_arready = s.arRdy;
  assign s_axi_rvalid  = s.rValid;
  assign s_axi_rdata   = s.rData;
  assign s_axi_rresp   = s.rResp;
  assign voltCode      = s.voltCode;
  assign voltEn        = s.voltEn;
  assign currCode      = s.currCode;
  assign currEn        = s.currEn;
  assign dacStrobe     = s.dacStrobe;

  // byte-lane merge of a write into an existing word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = data[8*b +: 8];
      end
    end
    return res;
  endfunction

  // clamp a signed 48-bit value into [lo, hi]
  function automatic logic [47:0] clamp(input logic signed [47:0] v,
                                        input logic signed [47:0] lo,
                                        input logic signed [47:0] hi);
    logic [47:0] res;
    res = v;
    if (v < lo) begin
      res = lo;
    end else if (v > hi) begin
      res = hi;
    end
    return res;
  endfunction

  always_comb begin
    logic signed [47:0] limV;
    logic signed [47:0] fullScale;
    logic signed [32:0] diff;
    logic signed [48:0] prod;
    logic signed [47:0] resV;
    logic signed [47:0] resI;
    logic signed [47:0] calW;
    logic [31:0]        cand;
    logic [3:0]         newMaxV;
    logic               inRange;
    limV      = '0;
    fullScale = '0;
    diff      = '0;
    prod      = '0;
    resV      = '0;
    resI      = '0;
    calW      = '0;
    cand      = '0;
    newMaxV   = '0;
    inRange   = 1'b0;
    n = s;
    n.dacStrobe = 1'b0;
    n.divStart  = 1'b0;

    // limiter with about ten percent over-range on top of the set maximum
    limV = $signed(48'(s.maxV) * 48'(dac_scaler_pkg::OVR_PER_VOLT));
    // the same zero and span feed both modes; before the divide only the scale differs
    if (s.mode == dac_scaler_pkg::MODE_CURR) begin
      fullScale = $signed(48'(dac_scaler_pkg::CUR_SPAN_UA));
    end else begin
      fullScale = $signed(48'(s.maxV) * 48'(dac_scaler_pkg::MV_PER_VOLT));
    end

    // AXI write address and data are taken independently, in any order
    if (s_axi_awvalid && s.awRdy) begin
      n.awAddr = s_axi_awaddr;
      n.awRdy  = 1'b0;
    end
    if (s_axi_wvalid && s.wRdy) begin
      n.wData = s_axi_wdata;
      n.wStrb = s_axi_wstrb;
      n.wRdy  = 1'b0;
    end

    // latest indicator sample; the fast-sampling stream only refreshes it
    if (indValid) begin
      n.sample     = indValue;
      n.haveSample = 1'b1;
    end

    // fixed-rate tick, derived from ref_clk only
    if (s.tickCnt >= CONV_CYCLES - 1) begin
      n.tickCnt = '0;
      // a zero span has no meaningful slope, so the output just holds
      if (!s.calTest && s.haveSample && !s.busy && s.span != 32'h0) begin
        diff = $signed({s.sample[31], s.sample}) - $signed({s.zero[31], s.zero});
        prod = diff * $signed({1'b0, fullScale[15:0]});
        n.divNum   = prod[47:0];
        n.divDen   = s.span;
        n.divStart = 1'b1;
        n.busy     = 1'b1;
      end
    end else begin
      n.tickCnt = s.tickCnt + 32'h1;
    end

    // quotient back: offset, clamp and present to the converter
    if (div.done && s.busy) begin
      n.busy = 1'b0;
      resV = $signed(clamp(div.quotient, -limV, limV));
      resI = $signed(clamp(div.quotient + $signed(48'(dac_scaler_pkg::CUR_ZERO_UA)),
                           $signed(48'(dac_scaler_pkg::CUR_LO_UA)),
                           $signed(48'(dac_scaler_pkg::CUR_HI_UA))));
      // a result landing after calibration test began is dropped
      if (!s.calTest) begin
        n.voltCode  = resV[15:0];
        n.currCode  = resI[15:0];
        n.dacStrobe = 1'b1;
      end
    end

    // one write at a time: once both halves are held and no response pends
    if (!s.awRdy && !s.wRdy && !s.bValid) begin
      n.bValid = 1'b1;
      n.bResp  = dac_scaler_pkg::RESP_OKAY;
      if (s.awAddr == dac_scaler_pkg::CTRL_OFFSET) begin
        if (s.wStrb[0]) begin
          n.mode    = dac_scaler_pkg::out_mode_e'(s.wData[dac_scaler_pkg::CTRL_MODE_BIT]);
          n.calTest = s.wData[dac_scaler_pkg::CTRL_CAL_BIT];
        end
        if (s.wStrb[1]) begin
          newMaxV = s.wData[dac_scaler_pkg::CTRL_MAXV_MSB:dac_scaler_pkg::CTRL_MAXV_LSB];
          // out-of-range limit settings saturate to the legal 1..10 V
          if (newMaxV < dac_scaler_pkg::MAXV_MIN) begin
            n.maxV = dac_scaler_pkg::MAXV_MIN;
          end else if (newMaxV > dac_scaler_pkg::MAXV_MAX) begin
            n.maxV = dac_scaler_pkg::MAXV_MAX;
          end else begin
            n.maxV = newMaxV;
          end
        end
      end else if (s.awAddr == dac_scaler_pkg::ZERO_OFFSET) begin
        n.zero = merge(s.zero, s.wData, s.wStrb);
      end else if (s.awAddr == dac_scaler_pkg::SPAN_OFFSET) begin
        n.span = merge(s.span, s.wData, s.wStrb);
      end else if (s.awAddr == dac_scaler_pkg::CALVAL_OFFSET) begin
        cand = merge(s.calVal, s.wData, s.wStrb);
        calW = $signed({{16{cand[31]}}, cand});
        if (s.mode == dac_scaler_pkg::MODE_CURR) begin
          inRange = (calW >= $signed(48'(dac_scaler_pkg::CUR_LO_UA))) &&
                    (calW <= $signed(48'(dac_scaler_pkg::CUR_HI_UA)));
        end else begin
          inRange = (calW >= -limV) && (calW <= limV);
        end
        if (!s.calTest) begin
          n.calVal = cand;
        end else if (inRange) begin
          // accepted entry goes straight to the active output
          n.calVal    = cand;
          n.voltCode  = cand[15:0];
          n.currCode  = cand[15:0];
          n.dacStrobe = 1'b1;
        end else begin
          n.rejected = 1'b1;
        end
      end else if (s.awAddr == dac_scaler_pkg::RATEDCAP_OFFSET) begin
        n.ratedCap = merge(s.ratedCap, s.wData, s.wStrb);
      end else if (s.awAddr == dac_scaler_pkg::CONFIRM_OFFSET) begin
        n.span = s.ratedCap;
      end else if (s.awAddr == dac_scaler_pkg::STATUS_OFFSET) begin
        // write one to clear; the only setter is a CALVAL write, never concurrent
        if (s.wStrb[0] && s.wData[dac_scaler_pkg::STAT_REJ_BIT]) begin
          n.rejected = 1'b0;
        end
      end else begin
        n.bResp = dac_scaler_pkg::RESP_SLVERR;
      end
    end
    if (s.bValid && s_axi_bready) begin
      n.bValid = 1'b0;
      n.awRdy  = 1'b1;
      n.wRdy   = 1'b1;
    end

    // read answers one cycle after the address is taken
    if (s_axi_arvalid && s.arRdy) begin
      n.arRdy  = 1'b0;
      n.rValid = 1'b1;
      n.rResp  = dac_scaler_pkg::RESP_OKAY;
      n.rData  = 32'h0;
      if (s_axi_araddr == dac_scaler_pkg::CTRL_OFFSET) begin
        n.rData[dac_scaler_pkg::CTRL_MODE_BIT] = s.mode;
        n.rData[dac_scaler_pkg::CTRL_CAL_BIT]  = s.calTest;
        n.rData[dac_scaler_pkg::CTRL_MAXV_MSB:dac_scaler_pkg::CTRL_MAXV_LSB] = s.maxV;
      end else if (s_axi_araddr == dac_scaler_pkg::ZERO_OFFSET) begin
        n.rData = s.zero;
      end else if (s_axi_araddr == dac_scaler_pkg::SPAN_OFFSET) begin
        n.rData = s.span;
      end else if (s_axi_araddr == dac_scaler_pkg::CALVAL_OFFSET) begin
        n.rData = s.calVal;
      end else if (s_axi_araddr == dac_scaler_pkg::RATEDCAP_OFFSET) begin
        n.rData = s.ratedCap;
      end else if (s_axi_araddr == dac_scaler_pkg::CONFIRM_OFFSET) begin
        n.rData = 32'h0;
      end else if (s_axi_araddr == dac_scaler_pkg::STATUS_OFFSET) begin
        n.rData[dac_scaler_pkg::STAT_REJ_BIT]  = s.rejected;
        n.rData[dac_scaler_pkg::STAT_BUSY_BIT] = s.busy;
        n.rData[dac_scaler_pkg::STAT_CODE_LSB +: 16] =
          (s.mode == dac_scaler_pkg::MODE_CURR) ? s.currCode : s.voltCode;
      end else begin
        n.rResp = dac_scaler_pkg::RESP_SLVERR;
      end
    end
    if (s.rValid && s_axi_rready) begin
      n.rValid = 1'b0;
      n.arRdy  = 1'b1;
    end

    // only the selected output is enabled; the idle one is parked at zero
    n.voltEn = (n.mode == dac_scaler_pkg::MODE_VOLT);
    n.currEn = (n.mode == dac_scaler_pkg::MODE_CURR);
    if (!n.voltEn) begin
      n.voltCode = 16'h0;
    end
    if (!n.currEn) begin
      n.currCode = 16'h0;
    end
  end

  // state register; reset leaves voltage mode at the full 10 V limit
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s          <= '0;
      s.awRdy    <= 1'b1;
      s.wRdy     <= 1'b1;
      s.arRdy    <= 1'b1;
      s.mode     <= dac_scaler_pkg::MODE_VOLT;
      s.maxV     <= dac_scaler_pkg::MAXV_RESET;
      s.zero     <= dac_scaler_pkg::ZERO_RESET;
      s.span     <= dac_scaler_pkg::SPAN_RESET;
      s.voltEn   <= 1'b1;
    end else begin
      s <= n;
    end
  end

endmodule // dac_output_scaler

//--- dac_scaler_properties.sv
// concurrent checks on the ports of the analog output scaler
module dac_scaler_properties #(
  parameter int unsigned CONV_CYCLES = 100
) (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [15:0] voltCode,
  input wire logic        voltEn,
  input wire logic [15:0] currCode,
  input wire logic        currEn,
  input wire logic        dacStrobe
);
  timeunit 1ns;
  timeprecision 1ps;
  // one clock domain, so clocking and reset are given once
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // exactly one output path is driven at any time
  enables_exclusive_a: assert property (voltEn != currEn)
    else $error("voltage and current enables not exclusive");
  inactive_zero_a: assert property ((voltEn |-> currCode == 16'h0) and (currEn |-> voltCode == 16'h0))
    else $error("inactive output code not zero");
  // strobe is a single-cycle pulse per code
  strobe_pulse_a: assert property (dacStrobe |=> !dacStrobe)
    else $error("dacStrobe longer than one cycle");
  // clamp at limit plus ten percent, widest limit is 10 V
  volt_clamp_a: assert property (voltEn && dacStrobe |->
    $signed(voltCode) <= 16'sh2af8 && $signed(voltCode) >= -16'sh2af8)
    else $error("voltage code beyond clamp");
  curr_clamp_a: assert property (currEn && dacStrobe |->
    currCode >= dac_scaler_pkg::CUR_LO_UA && currCode <= dac_scaler_pkg::CUR_HI_UA)
    else $error("current code beyond clamp");
  // bus answers stand until taken and come on time
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write answer late");
endmodule // dac_scaler_properties

bind dac_output_scaler dac_scaler_properties #(.CONV_CYCLES(CONV_CYCLES)) u_props (
  .ref_clk(ref_clk), .reset(reset), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .voltCode(voltCode),
  .voltEn(voltEn), .currCode(currCode), .currEn(currEn), .dacStrobe(dacStrobe));

//--- dac_stage_model.sv
// behavioural model of the isolated analog output stage
module dac_stage_model (
  input  wire logic        ref_clk,
  input  wire logic [15:0] voltCode,
  input  wire logic        voltEn,
  input  wire logic [15:0] currCode,
  input  wire logic        currEn,
  input  wire logic        dacStrobe,
  output logic      [15:0] heldVolt,
  output logic      [15:0] heldCurr,
  output logic             bothDriven
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    heldVolt = 16'h0;
    heldCurr = 16'h0;
    bothDriven = 1'b0;
  end
  // codes are taken only on the strobe, so a glitch between strobes is never output
  always @(posedge ref_clk) begin
    if (dacStrobe && voltEn) heldVolt <= voltCode;
    if (dacStrobe && currEn) heldCurr <= currCode;
    if (voltEn && currEn) bothDriven <= 1'b1;
  end
endmodule // dac_stage_model

//--- testbench.sv
// self-checking bench for the analog output scaler
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CONV = 100;
  localparam int IND [7] = '{100, 1100, 600, 1201, 2000, -1000, -5000};
  logic        ref_clk, reset, indValid, voltEn, currEn, dacStrobe, bothDriven;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, indValue, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] voltCode, currCode, heldVolt, heldCurr;
  int          err_count, n_compared, n, e, m;

  dac_output_scaler #(.CONV_CYCLES(CONV)) u_dut (.ref_clk(ref_clk), .reset(reset),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .indValid(indValid),
    .indValue(indValue), .voltCode(voltCode), .voltEn(voltEn), .currCode(currCode),
    .currEn(currEn), .dacStrobe(dacStrobe));
  dac_stage_model u_stage (.ref_clk(ref_clk), .voltCode(voltCode), .voltEn(voltEn),
    .currCode(currCode), .currEn(currEn), .dacStrobe(dacStrobe), .heldVolt(heldVolt),
    .heldCurr(heldCurr), .bothDriven(bothDriven));

  // 125 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ready is raised only once the answer shows, so the slave must hold it a cycle
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    k = 0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready) && k < 100);
    s_axi_bready <= 1'b0;
    // a write that never answers counts as a mismatch
    if (k >= 100) chk("bTimeout", 32'h0, 32'h1);
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready) && k < 100);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    // a read that never answers counts as a mismatch
    if (k >= 100) chk("rTimeout", 32'h0, 32'h1);
    chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
  endtask

  task automatic wait_strobe(output int c);
    c = 0;
    do begin
      @(posedge ref_clk);
      c++;
    end while (dacStrobe !== 1'b1 && c < 1000);
    if (c >= 1000) chk("dacStrobe", 32'h0, 32'h1);
  endtask

  // second strobe is sure to come from a divide that began after the change
  task automatic settle;
    wait_strobe(n);
    wait_strobe(n);
    @(negedge ref_clk);
  endtask

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, indValue, indValid} = 81'h0;
    s_axi_wstrb = 4'hf;
    reset = 1'b1;
    err_count = 0;
    n_compared = 0;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    axi_read(8'h00, 2'h0, rd); chk("ctrl", rd, 32'h0000_0a00);
    axi_read(8'h04, 2'h0, rd); chk("zero", rd, 32'h0);
    axi_read(8'h08, 2'h0, rd); chk("span", rd, 32'h0000_2710);
    axi_read(8'h1c, 2'h2, rd); chk("unmapped", rd, 32'h0);
    axi_write(8'h20, 32'h1, 2'h2);
    $display("test registers done");
    @(posedge ref_clk);
    indValid <= 1'b1;
    axi_write(8'h04, 32'h64, 2'h0);
    axi_write(8'h08, 32'h3e8, 2'h0);
    for (m = 10; m >= 5; m -= 5) begin
      axi_write(8'h00, 32'(m) << 8, 2'h0);
      foreach (IND[i]) begin
        indValue <= 32'(IND[i]);
        settle;
        e = (IND[i] - 100) * m * 1000 / 1000;
        e = (e > m * 1100) ? m * 1100 : (e < -m * 1100) ? -m * 1100 : e;
        chk("voltCode", {16'h0, heldVolt}, {16'h0, 16'(e)});
      end
    end
    wait_strobe(n);
    chk("period", 32'(n), 32'(CONV));
    $display("test voltage done");
    axi_write(8'h00, 32'h0000_0a01, 2'h0);
    foreach (IND[i]) begin
      indValue <= 32'(IND[i]);
      settle;
      e = 4000 + (IND[i] - 100) * 16;
      e = (e > 21600) ? 21600 : (e < 2400) ? 2400 : e;
      chk("currCode", {16'h0, heldCurr}, {16'h0, 16'(e)});
      chk("voltOff", {voltCode, 14'h0, voltEn, currEn}, 32'h1);
    end
    $display("test current done");
    axi_write(8'h00, 32'h0000_0502, 2'h0);
    axi_write(8'h0c, 32'h0000_0bb8, 2'h0);
    repeat (3) @(negedge ref_clk);
    chk("calVolt", {16'h0, heldVolt}, 32'h0000_0bb8);
    axi_write(8'h0c, 32'hffff_ea84, 2'h0);
    repeat (3) @(negedge ref_clk);
    chk("calEdge", {16'h0, heldVolt}, 32'h0000_ea84);
    axi_write(8'h0c, 32'h0000_157d, 2'h0);
    repeat (3) @(negedge ref_clk);
    chk("calKeep", {16'h0, heldVolt}, 32'h0000_ea84);
    axi_read(8'h18, 2'h0, rd); chk("rejected", {31'h0, rd[0]}, 32'h1);
    chk("statCode", {16'h0, rd[31:16]}, 32'h0000_ea84);
    $display("test calibration done");
    axi_write(8'h10, 32'h0000_1388, 2'h0);
    axi_write(8'h14, 32'h0000_0001, 2'h0);
    axi_read(8'h08, 2'h0, rd); chk("spanLoad", rd, 32'h0000_1388);
    chk("bothDriven", {31'h0, bothDriven}, 32'h0);
    $display("test capacity done");
    complete_run;
  end

  // the tests need some 4400 cycles; nearly seven times that means a hang
  initial begin
    repeat (30000) @(posedge ref_clk);
    err_count++;
    complete_run;
  end
endmodule // testbench
